// file: clk_stop_cfg.svh
// Constants for the clock stop and power-down controller
`ifndef CLK_STOP_CFG_SVH
`define CLK_STOP_CFG_SVH
`define CLK_PERIOD_NS 40
`define PD_SYNC_EDGES 2
`define STP_SYNC_EDGES 2
`define DIFF_PARK_MAX_PERIODS 4
`define CPU_STOP_MIN_PERIODS 2
`define CPU_STOP_MAX_PERIODS 6
`define CPU_RESUME_MAX_PERIODS 2
`define PCI_RESUME_MAX_PERIODS 2
`define POWER_UP_LATENCY_NS 1800000
`define POWER_UP_CYCLES (`POWER_UP_LATENCY_NS / `CLK_PERIOD_NS)
`define TRI_DRIVE_NS 300000
`define TRI_DRIVE_CYCLES (`TRI_DRIVE_NS / `CLK_PERIOD_NS)
`define CPU_DIV_HALF 1
`define PCI_DIV_HALF 2
`define SOFT_PCI_STOP_RESET 1'b1
`define CPU_STOP_EN_RESET 3'h7
`endif

// file: clk_stop_pkg.sv
// Types for the clock stop and power-down controller
package clk_stop_pkg;
  typedef enum logic [1:0] {PH_POWER_GOOD, PH_RUN, PH_PARKED, PH_WAKE} phase_t;
endpackage

// file: gated_clock_lane.sv
// One output lane: divided clock with glitch-free stop and park
`timescale 1ns/100ps
`include "clk_stop_cfg.svh"
module gated_clock_lane #(
  parameter int HALF = 1 // Enables per half period
) (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset, active high
  input wire logic tick, // Rate enable pulse
  input wire logic stop_req, // Request to stop
  input wire logic stop_high, // Park level: 1 high, 0 low
  output logic clk_out, // Lane clock level
  output logic stopped, // Lane is parked
  output logic fall_evt // Pulse on a falling transition
);
  import clk_stop_pkg::*;
  initial begin
    if (HALF < 1 || HALF > 255) $error("gated_clock_lane: HALF out of range");
  end
  typedef struct packed {
    logic [7:0] cnt; // Half-period counter
    logic lvl; // Clock level
    logic stp; // Parked flag
    logic fall; // Fall pulse
  } lane_t;
  lane_t st_reg, st_next;
  // Stop only at the fall, resume only from low; no runts either way
  always_comb begin
    st_next = st_reg;
    st_next.fall = 1'b0;
    if (tick) begin
      if (st_reg.stp) begin
        if (!stop_req) begin // Resume on the next half period
          st_next.stp = 1'b0;
          st_next.lvl = 1'b0;
          st_next.cnt = 8'h00;
        end
      end else if (st_reg.cnt == 8'(HALF - 1)) begin
        st_next.cnt = 8'h00;
        st_next.lvl = ~st_reg.lvl;
        if (st_reg.lvl) begin
          st_next.fall = 1'b1;
          st_next.stp = stop_req; // Park only at the fall
        end
      end else begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
  end
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign clk_out = st_reg.stp ? stop_high : st_reg.lvl;
  assign stopped = st_reg.stp;
  assign fall_evt = st_reg.fall;
endmodule // gated_clock_lane

// file: clock_stop_powerdown_ctrl.sv
// Power-down and group stop sequencing for the clock outputs
// Functional notes
// - Pin is power-good first, power-down after
// - Power-down synchronised in, async release accepted
// - Park all clocks before oscillators turn off
// - Two edges high; single-ended park low
// - Differential parks at complement fall, four periods
// - Mode 0: true high, complement tri-stated
// - Mode 1: both legs tri-stated; serial ref driven high instead once a wake has set tri_release
// - Stable clocks within 1.8 ms of release
// - Tri-stated outputs driven within 300 us
// - Outputs enabled together after PLL lock
// - CPU stop: two edges, stop in 2-6 periods
// - Stopped CPU: true high, complement tri-stated
// - CPU resume glitch-free within two cycles
// - PCI stop gates PCI clocks synchronously
// - Free-running PCI outputs ignore PCI stop unless their stop enable is set
// - PCI resume within two PCI periods
// - Pin or soft bit low stops PCI low
// - Soft bit reads 0 when either low
// - CPU stop enable per output
// - CPU stop drive mode per output
// - Power-down drive mode per CPU output, one for the serial ref group
`timescale 1ns/100ps
`include "clk_stop_cfg.svh"
module clock_stop_powerdown_ctrl #(
  parameter int NUM_CPU = 3, // CPU differential pairs
  parameter int NUM_FREE_RUNNING_PCI_CLK = 2, // Free-running PCI outputs
  parameter int POWER_UP_CYCLES = `POWER_UP_CYCLES, // Wake latency count
  parameter int TRI_DRIVE_CYCLES = `TRI_DRIVE_CYCLES // Tri-state release count
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic rst, // Sync reset, active high
  input wire logic power_good_n, // Shared pin level (power-good then power-down)
  input wire logic cpu_group_stop_n, // CPU group stop, active low
  input wire logic pci_group_stop_n, // PCI group stop, active low
  input wire logic soft_pci_group_stop, // Soft PCI stop bit written, 0 stops
  input wire logic [NUM_CPU-1:0] cpu_stop_en, // 1 = stoppable by CPU stop
  input wire logic [NUM_CPU-1:0] cpu_stop_tri, // 1 = tri-state when CPU stopped
  input wire logic [NUM_CPU-1:0] cpu_pd_tri, // 1 = tri-state in power-down
  input wire logic src_pd_tri, // Serial ref group tri-state in the first power-down after reset only
  input wire logic [NUM_FREE_RUNNING_PCI_CLK-1:0] free_running_pci_clk_stop_en, // 1 = free PCI stoppable
  output logic [NUM_CPU-1:0] cpu_clk_true, // CPU true legs
  output logic [NUM_CPU-1:0] cpu_clk_true_oe, // CPU true leg drive enable
  output logic [NUM_CPU-1:0] cpu_clk_comp, // CPU complement legs
  output logic [NUM_CPU-1:0] cpu_clk_comp_oe, // CPU complement drive enable
  output logic serial_link_ref_clk, // Serial ref true leg
  output logic serial_link_ref_clk_oe, // Serial ref drive enable
  output logic pci_clk, // Stoppable PCI clock
  output logic [NUM_FREE_RUNNING_PCI_CLK-1:0] free_running_pci_clk, // Free PCI clocks
  output logic soft_pci_group_stop_rd, // Soft bit readback
  output logic powered_down, // Power-down recognised
  output logic osc_enable, // Oscillators/VCO enabled
  output logic clocks_stable // Outputs enabled after lock
);
  import clk_stop_pkg::*;
  initial begin
    if (NUM_CPU < 1 || NUM_CPU > 8) $error("NUM_CPU out of range");
    if (NUM_FREE_RUNNING_PCI_CLK < 1 || NUM_FREE_RUNNING_PCI_CLK > 8) $error("NUM_FREE_RUNNING_PCI_CLK out of range");
    if (POWER_UP_CYCLES < 2 || TRI_DRIVE_CYCLES < 1) $error("bad counts");
    if (TRI_DRIVE_CYCLES > POWER_UP_CYCLES) $error("tri release after wake");
  end
  // All block state
  typedef struct packed {
    phase_t ph; // Sequencer phase
    logic pd_s1; // Power-down sync stage 1
    logic pd_s2; // Power-down sync stage 2
    logic pd_seen; // High on two CPU edges
    logic pd_hold; // Power-down level at the previous CPU tick
    logic cs_s1; // CPU stop sync stage 1
    logic cs_s2; // CPU stop sync stage 2
    logic cpu_div; // CPU rate enable toggle
    logic [1:0] pci_div; // PCI rate divider
    logic [20:0] wake_cnt; // Wake counter
    logic tri_release; // Drive tri-stated legs high
  } ctrl_t;
  ctrl_t st_reg, st_next;
  logic cpu_tick, pci_tick; // Rate enables
  logic pd_level; // Pin seen as power-down
  logic cpu_stop_act; // Qualified CPU stop
  logic pci_stop_act; // Combined PCI stop
  logic pd_park; // Lanes must park
  logic [NUM_CPU-1:0] cpu_lvl, cpu_parked, cpu_fall; // CPU lane state
  logic src_lvl, src_parked, src_fall; // Serial ref lane
  logic pci_lvl, pci_parked; // PCI lane
  logic [NUM_FREE_RUNNING_PCI_CLK-1:0] free_running_pci_clk_lvl, free_running_pci_clk_parked; // Free PCI lanes
  logic all_parked; // Every lane parked
  assign cpu_tick = st_reg.cpu_div;
  assign pci_tick = (st_reg.pci_div == 2'(`PCI_DIV_HALF));
  // Pin is power-good until first sampled low, then power-down
  assign pd_level = (st_reg.ph != PH_POWER_GOOD) & st_reg.pd_s2;
  assign cpu_stop_act = ~st_reg.cs_s2 & (st_reg.ph == PH_RUN);
  assign pci_stop_act = ~(pci_group_stop_n & soft_pci_group_stop);
  assign pd_park = (st_reg.ph == PH_PARKED) | st_reg.pd_seen;
  assign all_parked = (&cpu_parked) & src_parked & pci_parked & (&free_running_pci_clk_parked);
  // Sequencer and synchronisers
  always_comb begin
    st_next = st_reg;
    st_next.pd_s1 = power_good_n;
    st_next.pd_s2 = st_reg.pd_s1;
    st_next.cs_s1 = cpu_group_stop_n;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.cpu_div = ~st_reg.cpu_div;
    st_next.pci_div = pci_tick ? 2'h0 : st_reg.pci_div + 2'h1;
    // Two consecutive CPU-rate samples high recognise power-down
    // A lone high sample between ticks must not count
    if (cpu_tick) begin
      st_next.pd_hold = pd_level;
      st_next.pd_seen = pd_level & st_reg.pd_hold;
    end
    unique case (st_reg.ph)
      PH_POWER_GOOD: begin
        if (!st_reg.pd_s2) begin
          st_next.ph = PH_RUN;
        end
      end
      PH_RUN: begin
        // Oscillators stay on until every lane is parked
        if (st_reg.pd_seen && all_parked) begin
          st_next.ph = PH_PARKED;
        end
      end
      PH_PARKED: begin
        // Release taken as soon as the pin drops
        if (!st_reg.pd_s2) begin
          st_next.ph = PH_WAKE;
          st_next.wake_cnt = '0;
          st_next.tri_release = 1'b0;
          st_next.pd_seen = 1'b0;
        end
      end
      PH_WAKE: begin
        st_next.wake_cnt = st_reg.wake_cnt + 21'h1;
        if (st_reg.wake_cnt == 21'(TRI_DRIVE_CYCLES - 1)) begin
          st_next.tri_release = 1'b1;
        end
        if (st_reg.wake_cnt == 21'(POWER_UP_CYCLES - 1)) begin
          st_next.ph = PH_RUN;
        end
      end
    endcase
  end
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.pd_s1 <= 1'b1;
      st_reg.pd_s2 <= 1'b1;
      st_reg.cs_s1 <= 1'b1;
      st_reg.cs_s2 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // CPU lanes: stop and power-down each park true high or tri-stated, by their own modes
  for (genvar i = 0; i < NUM_CPU; i++) begin : g_cpu
    gated_clock_lane #(.HALF(`CPU_DIV_HALF)) u_lane (
      .clock(clock),
      .rst(rst),
      .tick(cpu_tick),
      .stop_req(pd_park | (cpu_stop_act & cpu_stop_en[i])),
      .stop_high(1'b1),
      .clk_out(cpu_lvl[i]),
      .stopped(cpu_parked[i]),
      .fall_evt(cpu_fall[i])
    );
    always_comb begin
      cpu_clk_true[i] = cpu_lvl[i] & clocks_stable;
      cpu_clk_comp[i] = ~cpu_lvl[i] & clocks_stable;
      cpu_clk_true_oe[i] = 1'b1;
      cpu_clk_comp_oe[i] = 1'b1;
      if (cpu_parked[i] && pd_park) begin
        cpu_clk_true[i] = 1'b1; // Held high even with oscillators off
        cpu_clk_comp_oe[i] = 1'b0;
        cpu_clk_true_oe[i] = ~cpu_pd_tri[i];
      end else if (cpu_parked[i]) begin
        cpu_clk_comp_oe[i] = 1'b0;
        cpu_clk_true_oe[i] = ~cpu_stop_tri[i];
      end else if (st_reg.ph == PH_WAKE) begin
        cpu_clk_true[i] = st_reg.tri_release;
        cpu_clk_true_oe[i] = st_reg.tri_release | ~cpu_pd_tri[i];
        cpu_clk_comp_oe[i] = 1'b0;
      end
    end
  end
  // Serial reference lane parks only on power-down, with group power-down mode
  gated_clock_lane #(.HALF(`CPU_DIV_HALF)) u_src (
    .clock(clock),
    .rst(rst),
    .tick(cpu_tick),
    .stop_req(pd_park),
    .stop_high(1'b1),
    .clk_out(src_lvl),
    .stopped(src_parked),
    .fall_evt(src_fall)
  );
  // Parked level stays high through power-down
  assign serial_link_ref_clk = (src_lvl & (clocks_stable | (src_parked & pd_park))) |
    (st_reg.ph == PH_WAKE && st_reg.tri_release);
  assign serial_link_ref_clk_oe = ~((src_parked | st_reg.ph == PH_WAKE) & src_pd_tri & ~st_reg.tri_release);
  // PCI lane parks low on stop or power-down
  gated_clock_lane #(.HALF(`PCI_DIV_HALF)) u_pci (
    .clock(clock),
    .rst(rst),
    .tick(pci_tick),
    .stop_req(pd_park | pci_stop_act),
    .stop_high(1'b0),
    .clk_out(pci_lvl),
    .stopped(pci_parked),
    .fall_evt()
  );
  assign pci_clk = pci_lvl & clocks_stable;
  for (genvar j = 0; j < NUM_FREE_RUNNING_PCI_CLK; j++) begin : g_free_running_pci_clk
    gated_clock_lane #(.HALF(`PCI_DIV_HALF)) u_lane (
      .clock(clock),
      .rst(rst),
      .tick(pci_tick),
      .stop_req(pd_park | (pci_stop_act & free_running_pci_clk_stop_en[j])),
      .stop_high(1'b0),
      .clk_out(free_running_pci_clk_lvl[j]),
      .stopped(free_running_pci_clk_parked[j]),
      .fall_evt()
    );
  end
  assign free_running_pci_clk = free_running_pci_clk_lvl & {NUM_FREE_RUNNING_PCI_CLK{clocks_stable}};
  assign soft_pci_group_stop_rd = ~pci_stop_act;
  assign powered_down = st_reg.ph == PH_PARKED;
  assign osc_enable = st_reg.ph != PH_PARKED;
  // All lanes released together from one flag
  assign clocks_stable = st_reg.ph == PH_RUN;

  // Assertions
  logic [3:0] stop_age; // Cycles since CPU stop qualified
  always_ff @(posedge clock) begin
    if (rst || !cpu_stop_act) begin
      stop_age <= 4'h0;
    end else if (stop_age != 4'hf) begin
      stop_age <= stop_age + 4'h1;
    end
  end
  property p_pd_two_edges;
    @(posedge clock) disable iff (rst) $rose(st_reg.pd_seen) |-> $past(pd_level) && $past(pd_level, 3);
  endproperty
  a_pd_two_edges: assert property (p_pd_two_edges) else $error("power-down seen too early");
  property p_park_before_osc;
    @(posedge clock) disable iff (rst) $fell(osc_enable) |-> $past(all_parked);
  endproperty
  a_park_before_osc: assert property (p_park_before_osc) else $error("oscillator off before park");
  property p_cpu_stop_bound;
    @(posedge clock) disable iff (rst) (stop_age == 4'hc) && cpu_stop_en[0] |-> cpu_parked[0];
  endproperty
  a_cpu_stop_bound: assert property (p_cpu_stop_bound) else $error("CPU not stopped in time");
  property p_cpu_stop_level;
    @(posedge clock) disable iff (rst) cpu_parked[0] && !pd_park && clocks_stable |->
      cpu_clk_true[0] && !cpu_clk_comp_oe[0];
  endproperty
  a_cpu_stop_level: assert property (p_cpu_stop_level) else $error("stopped CPU complement driven");
  property p_cpu_resume;
    @(posedge clock) disable iff (rst) $rose(st_reg.cs_s2) && !pd_park |-> ##[1:4] !cpu_parked[0];
  endproperty
  a_cpu_resume: assert property (p_cpu_resume) else $error("CPU resume late");
  property p_pci_free;
    @(posedge clock) disable iff (rst) !pd_park && clocks_stable |-> (free_running_pci_clk_parked & ~free_running_pci_clk_stop_en) == '0;
  endproperty
  a_pci_free: assert property (p_pci_free) else $error("free PCI output stopped");
  property p_pci_low;
    @(posedge clock) disable iff (rst) pci_parked |-> !pci_clk;
  endproperty
  a_pci_low: assert property (p_pci_low) else $error("PCI parked high");
  property p_soft_read;
    @(posedge clock) disable iff (rst) !soft_pci_group_stop |-> !soft_pci_group_stop_rd;
  endproperty
  a_soft_read: assert property (p_soft_read) else $error("soft stop readback wrong");
  property p_pd_tri;
    @(posedge clock) disable iff (rst) powered_down |-> (cpu_clk_true_oe == ~cpu_pd_tri) && (cpu_clk_comp_oe == '0)
      && ((cpu_clk_true | cpu_pd_tri) == '1);
  endproperty
  a_pd_tri: assert property (p_pd_tri) else $error("power-down drive mode wrong");
  property p_park_at_fall;
    @(posedge clock) disable iff (rst) $rose(cpu_parked[0]) |-> cpu_fall[0];
  endproperty
  a_park_at_fall: assert property (p_park_at_fall) else $error("CPU parked off its fall");
  property p_src_park_fall;
    @(posedge clock) disable iff (rst) $rose(src_parked) |-> src_fall;
  endproperty
  a_src_park_fall: assert property (p_src_park_fall) else $error("serial ref parked off its fall");
  c_power_down: cover property (@(posedge clock) disable iff (rst) $rose(powered_down));
  c_cpu_stop: cover property (@(posedge clock) disable iff (rst) $rose(cpu_parked[0]) && !pd_park);
  c_pci_stop: cover property (@(posedge clock) disable iff (rst) $rose(pci_parked) && !pd_park);
  c_wake: cover property (@(posedge clock) disable iff (rst) $rose(clocks_stable));
endmodule // clock_stop_powerdown_ctrl

// file: power_mgmt_model.sv
// Power-management partner that drives the shared pin and the group stop inputs
`timescale 1ns/100ps
module power_mgmt_model (
  input wire logic clock, // System clock
  output logic power_good_n, // Shared pin, power-good then power-down
  output logic cpu_group_stop_n, // CPU group stop, active low
  output logic pci_group_stop_n // PCI group stop, active low
);
  localparam int PD_LIMIT_CYCLES = 250; // Longest wait before power-down, 10 us at 40 ns

  // Board pull-ups leave every line inactive until the model acts
  initial begin
    power_good_n = 1'b1;
    cpu_group_stop_n = 1'b1;
    pci_group_stop_n = 1'b1;
  end

  // Change one line just after the edge so the device samples a settled level
  task drive(input int pin, input logic lvl);
    @(posedge clock);
    #1;
    case (pin)
      0: power_good_n = lvl;
      1: cpu_group_stop_n = lvl;
      default: pci_group_stop_n = lvl;
    endcase
  endtask

  // Power-good, optionally followed by power-down as the first state
  task power_on(input bit start_down);
    drive(0, 1'b0);
    if (start_down) begin
      repeat (PD_LIMIT_CYCLES / 10) @(posedge clock);
      drive(0, 1'b1);
    end
  endtask
endmodule // power_mgmt_model

// file: tb_top.sv
// Self-checking bench for the clock stop and power-down controller
`timescale 1ns/100ps
module tb_top;
  localparam int PU = 40; // Shortened wake latency
  localparam int TRI = 10; // Shortened tri-state release
  logic clock, rst, power_good_n, cpu_group_stop_n, pci_group_stop_n, soft_pci_group_stop, src_pd_tri;
  logic [2:0] cpu_stop_en, cpu_stop_tri, cpu_pd_tri, cpu_clk_true, cpu_clk_true_oe, cpu_clk_comp, cpu_clk_comp_oe;
  logic [1:0] free_running_pci_clk_stop_en, free_running_pci_clk;
  logic serial_link_ref_clk, serial_link_ref_clk_oe, pci_clk, soft_pci_group_stop_rd;
  logic powered_down, osc_enable, clocks_stable;
  logic [6:0] clks; // All clock levels but the CPU complements in one vector
  int n_mismatch = 0;
  int checked = 0;

  assign clks = {free_running_pci_clk, pci_clk, serial_link_ref_clk, cpu_clk_true};

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  power_mgmt_model pm (.clock(clock), .power_good_n(power_good_n), .cpu_group_stop_n(cpu_group_stop_n),
    .pci_group_stop_n(pci_group_stop_n));

  clock_stop_powerdown_ctrl #(.NUM_CPU(3), .NUM_FREE_RUNNING_PCI_CLK(2), .POWER_UP_CYCLES(PU), .TRI_DRIVE_CYCLES(TRI)) DUT (
    .clock(clock), .rst(rst), .power_good_n(power_good_n), .cpu_group_stop_n(cpu_group_stop_n),
    .pci_group_stop_n(pci_group_stop_n), .soft_pci_group_stop(soft_pci_group_stop), .cpu_stop_en(cpu_stop_en),
    .cpu_stop_tri(cpu_stop_tri), .cpu_pd_tri(cpu_pd_tri), .src_pd_tri(src_pd_tri), .free_running_pci_clk_stop_en(free_running_pci_clk_stop_en),
    .cpu_clk_true(cpu_clk_true), .cpu_clk_true_oe(cpu_clk_true_oe), .cpu_clk_comp(cpu_clk_comp),
    .cpu_clk_comp_oe(cpu_clk_comp_oe), .serial_link_ref_clk(serial_link_ref_clk),
    .serial_link_ref_clk_oe(serial_link_ref_clk_oe), .pci_clk(pci_clk), .free_running_pci_clk(free_running_pci_clk),
    .soft_pci_group_stop_rd(soft_pci_group_stop_rd), .powered_down(powered_down), .osc_enable(osc_enable),
    .clocks_stable(clocks_stable));

  // Masked vector compare, masks out legs that float
  task check_vec(input logic [6:0] got, input logic [6:0] exp, input logic [6:0] mask);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      n_mismatch++;
      $display("ERROR at %0t: vector got %b expected %b mask %b", $time, got, exp, mask);
    end
  endtask

  // Single flag compare
  task check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  // Conditions awaited under a bound
  function automatic logic cond(input int k);
    case (k)
      0: return powered_down === 1'b1;
      1: return cpu_clk_true_oe === 3'b111 && serial_link_ref_clk_oe === 1'b1;
      default: return clocks_stable === 1'b1;
    endcase
  endfunction

  // Bounded wait; a miss shows up as a failed flag
  task wait_for(input int k, input int limit);
    int i;
    for (i = 0; i < limit && !cond(k); i++) begin
      @(posedge clock);
      #2;
    end
    check_flag(cond(k), 1'b1);
  endtask

  // Which clocks toggled over n cycles, and where they ended
  task observe(input int n, output logic [6:0] tog, output logic [6:0] last);
    logic [6:0] prev;
    #2; // Let the edge's updates settle before the first sample
    tog = '0;
    prev = clks;
    repeat (n) begin
      @(posedge clock);
      #2;
      tog = tog | (clks ^ prev);
      prev = clks;
    end
    last = clks;
  endtask

  // Single place where the run ends
  task print_verdict;
    $display("Counts: checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cut a hang short, far beyond the expected run length
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [6:0] tog, last;
    rst = 1'b1;
    soft_pci_group_stop = 1'b1;
    cpu_stop_en = 3'b101;
    cpu_stop_tri = 3'b100;
    cpu_pd_tri = 3'b010;
    src_pd_tri = 1'b1;
    free_running_pci_clk_stop_en = 2'b01;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    check_flag(clocks_stable, 1'b0);
    check_flag(osc_enable, 1'b1);
    pm.power_on(1'b0);
    wait_for(2, PU + 20);
    observe(16, tog, last);
    check_vec(tog, 7'h7f, 7'h7f);
    check_vec({4'h0, cpu_clk_comp}, {4'h0, ~cpu_clk_true}, 7'h07);
    check_flag(soft_pci_group_stop_rd, 1'b1);
    // CPU stop: lanes 0 and 2 stoppable, lane 2 floats its true leg
    pm.drive(1, 1'b0);
    repeat (30) @(posedge clock);
    observe(16, tog, last);
    check_vec(tog, 7'h7a, 7'h7f);
    check_vec(last, 7'h05, 7'h05);
    check_vec({4'h0, cpu_clk_comp}, 7'h00, 7'h05);
    check_vec({1'b0, cpu_clk_comp_oe, cpu_clk_true_oe}, 7'h13, 7'h3f);
    pm.drive(1, 1'b1);
    observe(14, tog, last);
    check_vec(tog, 7'h05, 7'h05);
    // PCI stop from the pin, then from the soft bit
    for (int k = 0; k < 2; k++) begin
      if (k == 0) pm.drive(2, 1'b0);
      else begin
        @(posedge clock);
        #1 soft_pci_group_stop = 1'b0;
      end
      repeat (12) @(posedge clock);
      observe(18, tog, last);
      check_vec(tog, 7'h4f, 7'h7f);
      check_vec(last, 7'h00, 7'h30);
      check_flag(soft_pci_group_stop_rd, 1'b0);
      if (k == 0) pm.drive(2, 1'b1);
      else begin
        @(posedge clock);
        #1 soft_pci_group_stop = 1'b1;
      end
      observe(14, tog, last);
      check_vec(tog, 7'h30, 7'h30);
    end
    // One-cycle pulse must not count as power-down
    pm.drive(0, 1'b1);
    pm.drive(0, 1'b0);
    repeat (20) @(posedge clock);
    check_flag(powered_down, 1'b0);
    pm.drive(0, 1'b1);
    wait_for(0, 30);
    check_flag(osc_enable, 1'b0);
    observe(8, tog, last);
    check_vec(tog, 7'h00, 7'h7f);
    check_vec(last, 7'h05, 7'h75);
    check_vec({serial_link_ref_clk_oe, cpu_clk_comp_oe, cpu_clk_true_oe}, 7'h05, 7'h7f);
    // Wake: floating legs driven first, then stable clocks
    pm.drive(0, 1'b0);
    wait_for(1, TRI + 10);
    wait_for(2, PU + 10);
    check_flag(powered_down, 1'b0);
    // Second reset: power-down as the first state
    @(posedge clock);
    #1 rst = 1'b1;
    pm.drive(0, 1'b1);
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    repeat (10) @(posedge clock);
    check_flag(powered_down, 1'b0);
    pm.power_on(1'b1);
    wait_for(0, 60);
    print_verdict();
  end
endmodule // tb_top
